/* hw/serial_port_pkg.sv */
// Purpose: shared constants of the four-mode serial port
// Assumes: aclk is the oscillator clock, 100 MHz
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus
package serial_port_pkg;

	// rate figures
	localparam int OVERSAMPLE         = 16;
	localparam int OSC_DIV_MODE0      = 12;
	localparam int OSC_DIV_MODE2      = 64;
	localparam int OSC_DIV_MODE2_FAST = 32;
	localparam int T1_DIV_BASE        = 32;
	localparam int M2_TICK_DIV        = OSC_DIV_MODE2 / OVERSAMPLE;
	localparam int M2_TICK_DIV_FAST   = OSC_DIV_MODE2_FAST / OVERSAMPLE;
	localparam int T1_PRESCALE        = T1_DIV_BASE / OVERSAMPLE;

	// cycle counts
	localparam logic [3:0] M0_LAST   = 4'(OSC_DIV_MODE0 - 1);
	localparam logic [3:0] M0_HALF   = 4'(OSC_DIV_MODE0 / 2);
	localparam logic [3:0] BIT_LAST  = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] START_MID = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] BITS_8N   = 4'ha;
	localparam logic [3:0] BITS_9N   = 4'hb;
	localparam logic [3:0] RX_SAMPLES_LAST = 4'h8;
	localparam logic [2:0] M0_BITS_LAST    = 3'h7;

	// mode codes {mode_select_high, mode_select_low}
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT  = 2'h1;

	// register byte offsets
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TXDATA = 4'h8;
	localparam logic [3:0] ADDR_RXDATA = 4'hc;

	// control register fields
	localparam int CTRL_MODE_LOW  = 0;
	localparam int CTRL_MODE_HIGH = 1;
	localparam int CTRL_RX_EN     = 2;
	localparam int CTRL_DBL_RATE  = 3;
	localparam int CTRL_TX_T2     = 4;
	localparam int CTRL_RX_T2     = 5;
	localparam int CTRL_TX_NINTH  = 6;

	// status register fields
	localparam int STAT_RX_DONE  = 0;
	localparam int STAT_TX_DONE  = 1;
	localparam int STAT_T2_OVF   = 2;
	localparam int STAT_RX_AVAIL = 3;
	localparam int STAT_TX_BUSY  = 4;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/rx_word_fifo.sv */
// Purpose: small received-word buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   in_ready drops when full so the receiver holds its word
`timescale 1ns/1ps
module rx_word_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               count;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic        push;
	logic        pop;

	assign in_ready  = s.count != CW'(DEPTH);
	assign out_valid = s.count != '0;
	assign out_data  = s.mem[s.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
		end
		if (push && !pop) begin
			next_s.count = s.count + 1'b1;
		end else if (pop && !push) begin
			next_s.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // rx_word_fifo

/* hw/baud_tick_gen.sv */
// Purpose: 16x baudrate clock enable for one direction
// Assumes: timer overflows are one-cycle pulses on aclk
// Notes:   mode 0 makes no tick here; its shift clock is timed elsewhere
`timescale 1ns/1ps
module baud_tick_gen (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// configuration
	input  wire logic [1:0] mode,
	input  wire logic       double_rate_bit,
	input  wire logic       timer2_sel,
	// timer overflow pulses
	input  wire logic       timer1_overflow,
	input  wire logic       timer2_overflow,
	// 16x enable
	output logic            tick16
);
	typedef struct packed {
		logic [5:0] cnt;
		logic       half;
		logic       tick;
	} baud_state_t;

	baud_state_t s;
	baud_state_t next_s;
	logic [5:0]  m2_last;
	logic        m2_slow;

	assign m2_slow = mode == 2'h2 && !double_rate_bit;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		m2_last = double_rate_bit ? 6'(serial_port_pkg::M2_TICK_DIV_FAST - 1)
		                          : 6'(serial_port_pkg::M2_TICK_DIV - 1);
		if (mode == serial_port_pkg::MODE_SHIFT) begin
			next_s.cnt = '0;
		end else if (!mode[0]) begin
			// fixed rate taken straight from the oscillator
			if (s.cnt >= m2_last) begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 6'h1;
			end
		end else if (timer2_sel) begin
			next_s.tick = timer2_overflow;
		end else if (timer1_overflow) begin
			// halving undone by the double-rate bit
			next_s.half = !s.half;
			next_s.tick = double_rate_bit || s.half;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick16 = s.tick;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// looks back so a rate change between two ticks cannot fire it
	mode2_slow_a: assert property ((tick16 && $past(m2_slow, 1)
		&& $past(m2_slow, 2) && $past(m2_slow, 3) && $past(m2_slow, 4)
		&& $past(m2_slow, 5)) |-> (!$past(tick16, 1) && !$past(tick16, 2)
		&& !$past(tick16, 3) && $past(tick16, 4)))
		else $error("mode 2 tick period is not four clocks");
	t2_tick_a: assert property ((mode[0] && timer2_sel && timer2_overflow)
		|=> tick16)
		else $error("timer 2 overflow did not give a tick");
	t1_half_a: assert property ((mode[0] && !timer2_sel && !double_rate_bit
		&& timer1_overflow && !s.half) |=> !tick16)
		else $error("timer 1 overflow not halved");
endmodule // baud_tick_gen

/* hw/serial_port_four_mode.sv */
// Purpose: four-mode full duplex serial port behind an AXI4-Lite slave
// Assumes: aclk is the oscillator; timer overflows are aclk pulses
// Notes:   receive pin is two-way in mode 0; transmit pin is its clock
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module serial_port_four_mode (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// serial pins
	input  wire logic        rxd_in,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             txd,
	// timer overflow pulses
	input  wire logic        timer1_overflow,
	input  wire logic        timer2_overflow,
	// interrupt request
	output logic             serial_irq
);
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLD} rx_state_t;

	typedef struct packed {
		logic        mode_select_high;
		logic        mode_select_low;
		logic        rx_enable;
		logic        double_rate_bit;
		logic        tx_timer2_clock_select;
		logic        rx_timer2_clock_select;
		logic        tx_ninth;
		logic        receive_complete_flag;
		logic        transmit_complete_flag;
		logic        timer2_overflow_flag;
		logic        awready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        rxd_s1;
		logic        rxd_s2;
		tx_state_t   tx_state;
		logic [10:0] tx_shift;
		logic [3:0]  tx_bits;
		logic [3:0]  tx_sub;
		logic        txd;
		logic        m0_active;
		logic        m0_is_tx;
		logic [3:0]  m0_cnt;
		logic [2:0]  m0_bits;
		logic [7:0]  m0_shift;
		logic        rxd_out;
		logic        rxd_oe;
		rx_state_t   rx_state;
		logic [3:0]  rx_sub;
		logic [3:0]  rx_bits;
		logic [8:0]  rx_shift;
		logic        irq;
	} port_state_t;

	port_state_t s;
	port_state_t next_s;
	logic [1:0]  mode;
	logic        nine_bit;
	logic        wr_go;
	logic        rd_go;
	logic        tx_load;
	logic        rx_pop;
	logic        tx_tick;
	logic        rx_tick;
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [8:0]  fifo_out_data;
	logic        rx_push;
	logic [7:0]  m0_next;

	assign mode     = {s.mode_select_high, s.mode_select_low};
	assign nine_bit = s.mode_select_high;
	assign wr_go    = s.awready && awvalid && wvalid;
	assign rd_go    = s.arready && arvalid;
	assign rx_pop   = rd_go && araddr == serial_port_pkg::ADDR_RXDATA;
	assign fifo_in_valid = s.rx_state == RX_HOLD;
	assign rx_push  = fifo_in_valid && fifo_in_ready;

	// each direction has its own baud source
	baud_tick_gen tx_baud (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.mode            (mode),
		.double_rate_bit (s.double_rate_bit),
		.timer2_sel      (s.tx_timer2_clock_select),
		.timer1_overflow (timer1_overflow),
		.timer2_overflow (timer2_overflow),
		.tick16          (tx_tick)
	);
	baud_tick_gen rx_baud (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.mode            (mode),
		.double_rate_bit (s.double_rate_bit),
		.timer2_sel      (s.rx_timer2_clock_select),
		.timer1_overflow (timer1_overflow),
		.timer2_overflow (timer2_overflow),
		.tick16          (rx_tick)
	);

	rx_word_fifo #(
		.WIDTH (9),
		.DEPTH (2)
	) rx_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (s.rx_shift),
		.out_valid (fifo_out_valid),
		.out_ready (rx_pop),
		.out_data  (fifo_out_data)
	);

	always_comb begin
		next_s = s;
		tx_load = 1'b0;
		m0_next = s.m0_shift;
		next_s.rxd_s1 = rxd_in;
		next_s.rxd_s2 = s.rxd_s1;

		// write channel: accept address and data together, answer after
		next_s.awready = 1'b0;
		if (awvalid && wvalid && !s.awready && !s.bvalid) begin
			next_s.awready = 1'b1;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = serial_port_pkg::RESP_OKAY;
			if (awaddr == serial_port_pkg::ADDR_CTRL) begin
				if (wstrb[0]) begin
					next_s.mode_select_low = wdata[serial_port_pkg::CTRL_MODE_LOW];
					next_s.mode_select_high = wdata[serial_port_pkg::CTRL_MODE_HIGH];
					next_s.rx_enable = wdata[serial_port_pkg::CTRL_RX_EN];
					next_s.double_rate_bit = wdata[serial_port_pkg::CTRL_DBL_RATE];
					next_s.tx_timer2_clock_select = wdata[serial_port_pkg::CTRL_TX_T2];
					next_s.rx_timer2_clock_select = wdata[serial_port_pkg::CTRL_RX_T2];
					next_s.tx_ninth = wdata[serial_port_pkg::CTRL_TX_NINTH];
				end
			end else if (awaddr == serial_port_pkg::ADDR_STATUS) begin
				// write one to clear; hardware sets below win
				if (wstrb[0] && wdata[serial_port_pkg::STAT_RX_DONE]) begin
					next_s.receive_complete_flag = 1'b0;
				end
				if (wstrb[0] && wdata[serial_port_pkg::STAT_TX_DONE]) begin
					next_s.transmit_complete_flag = 1'b0;
				end
				if (wstrb[0] && wdata[serial_port_pkg::STAT_T2_OVF]) begin
					next_s.timer2_overflow_flag = 1'b0;
				end
			end else if (awaddr == serial_port_pkg::ADDR_TXDATA) begin
				// a write while busy is dropped, not queued
				tx_load = wstrb[0] && s.tx_state == TX_IDLE && !s.m0_active;
			end else begin
				next_s.bresp = serial_port_pkg::RESP_SLVERR;
			end
		end

		// read channel
		next_s.arready = 1'b0;
		if (arvalid && !s.arready && !s.rvalid) begin
			next_s.arready = 1'b1;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = serial_port_pkg::RESP_OKAY;
			next_s.rdata = 32'h0;
			if (araddr == serial_port_pkg::ADDR_CTRL) begin
				next_s.rdata[6:0] = {s.tx_ninth, s.rx_timer2_clock_select,
					s.tx_timer2_clock_select, s.double_rate_bit, s.rx_enable,
					s.mode_select_high, s.mode_select_low};
			end else if (araddr == serial_port_pkg::ADDR_STATUS) begin
				next_s.rdata[4:0] = {s.tx_state == TX_SHIFT || s.m0_active,
					fifo_out_valid, s.timer2_overflow_flag,
					s.transmit_complete_flag, s.receive_complete_flag};
			end else if (araddr == serial_port_pkg::ADDR_RXDATA) begin
				next_s.rdata[8:0] = fifo_out_valid ? fifo_out_data : 9'h0;
			end else if (araddr != serial_port_pkg::ADDR_TXDATA) begin
				next_s.rresp = serial_port_pkg::RESP_SLVERR;
			end
		end

		// timer 2 as baud source keeps its overflow flag quiet
		if (timer2_overflow && !(s.tx_timer2_clock_select
			|| s.rx_timer2_clock_select)) begin
			next_s.timer2_overflow_flag = 1'b1;
		end

		// asynchronous transmitter, 16 ticks per bit
		case (s.tx_state)
			TX_IDLE: begin
				if (tx_load && mode != serial_port_pkg::MODE_SHIFT) begin
					next_s.tx_shift = {1'b1, nine_bit ? s.tx_ninth : 1'b1,
						wdata[7:0], 1'b0};
					next_s.tx_bits = nine_bit ? serial_port_pkg::BITS_9N
					                          : serial_port_pkg::BITS_8N;
					next_s.tx_sub = 4'h0;
					next_s.tx_state = TX_SHIFT;
				end
			end
			default: begin
				if (tx_tick) begin
					if (s.tx_sub == serial_port_pkg::BIT_LAST) begin
						next_s.tx_sub = 4'h0;
						next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
						next_s.tx_bits = s.tx_bits - 4'h1;
						if (s.tx_bits == 4'h1) begin
							next_s.tx_state = TX_IDLE;
							next_s.transmit_complete_flag = 1'b1;
						end
					end else begin
						next_s.tx_sub = s.tx_sub + 4'h1;
					end
				end
			end
		endcase

		// asynchronous receiver: start, then nine samples at bit centres
		case (s.rx_state)
			RX_IDLE: begin
				if (mode != serial_port_pkg::MODE_SHIFT && s.rx_enable
					&& rx_tick && !s.rxd_s2) begin
					next_s.rx_sub = 4'h0;
					next_s.rx_state = RX_START;
				end
			end
			RX_START: begin
				if (rx_tick) begin
					if (s.rx_sub == serial_port_pkg::START_MID) begin
						// a glitch shorter than half a bit is not a start
						next_s.rx_state = s.rxd_s2 ? RX_IDLE : RX_DATA;
						next_s.rx_sub = 4'h0;
						next_s.rx_bits = 4'h0;
					end else begin
						next_s.rx_sub = s.rx_sub + 4'h1;
					end
				end
			end
			RX_DATA: begin
				if (rx_tick) begin
					if (s.rx_sub == serial_port_pkg::BIT_LAST) begin
						next_s.rx_sub = 4'h0;
						next_s.rx_shift = {s.rxd_s2, s.rx_shift[8:1]};
						next_s.rx_bits = s.rx_bits + 4'h1;
						if (s.rx_bits == serial_port_pkg::RX_SAMPLES_LAST) begin
							next_s.rx_state = RX_HOLD;
						end
					end else begin
						next_s.rx_sub = s.rx_sub + 4'h1;
					end
				end
			end
			default: begin
				// held here while the buffer is full, so this word is kept; no new start is seen meanwhile
				if (rx_push) begin
					next_s.rx_state = RX_IDLE;
					next_s.receive_complete_flag = 1'b1;
				end
			end
		endcase

		// mode 0 shift register, one bit every twelve oscillator clocks
		if (!s.m0_active) begin
			if (mode == serial_port_pkg::MODE_SHIFT && tx_load) begin
				next_s.m0_active = 1'b1;
				next_s.m0_is_tx = 1'b1;
				next_s.m0_shift = wdata[7:0];
				next_s.m0_cnt = 4'h0;
				next_s.m0_bits = 3'h0;
			end else if (mode == serial_port_pkg::MODE_SHIFT && s.rx_enable
				&& !s.receive_complete_flag && s.rx_state == RX_IDLE) begin
				next_s.m0_active = 1'b1;
				next_s.m0_is_tx = 1'b0;
				next_s.m0_cnt = 4'h0;
				next_s.m0_bits = 3'h0;
			end
		end else if (s.m0_cnt == serial_port_pkg::M0_LAST) begin
			// data is sampled or advanced on the falling shift clock
			m0_next = s.m0_is_tx ? {1'b1, s.m0_shift[7:1]}
			                     : {s.rxd_s2, s.m0_shift[7:1]};
			next_s.m0_shift = m0_next;
			next_s.m0_cnt = 4'h0;
			next_s.m0_bits = s.m0_bits + 3'h1;
			if (s.m0_bits == serial_port_pkg::M0_BITS_LAST) begin
				next_s.m0_active = 1'b0;
				if (s.m0_is_tx) begin
					next_s.transmit_complete_flag = 1'b1;
				end else begin
					next_s.rx_shift = {1'b0, m0_next};
					next_s.rx_state = RX_HOLD;
				end
			end
		end else begin
			next_s.m0_cnt = s.m0_cnt + 4'h1;
		end

		// pins
		if (mode == serial_port_pkg::MODE_SHIFT) begin
			next_s.txd = !(next_s.m0_active
				&& next_s.m0_cnt < serial_port_pkg::M0_HALF);
		end else begin
			next_s.txd = next_s.tx_shift[0];
		end
		next_s.rxd_oe = next_s.m0_active && next_s.m0_is_tx;
		next_s.rxd_out = next_s.m0_shift[0];
		next_s.irq = next_s.receive_complete_flag
			|| next_s.transmit_complete_flag;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.tx_shift <= 11'h7ff;
			s.txd <= 1'b1;
			s.rxd_s1 <= 1'b1;
			s.rxd_s2 <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign awready    = s.awready;
	assign wready     = s.awready;
	assign bvalid     = s.bvalid;
	assign bresp      = s.bresp;
	assign arready    = s.arready;
	assign rvalid     = s.rvalid;
	assign rresp      = s.rresp;
	assign rdata      = s.rdata;
	assign txd        = s.txd;
	assign rxd_out    = s.rxd_out;
	assign rxd_oe     = s.rxd_oe;
	assign serial_irq = s.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	irq_from_flags_a: assert property ($rose(s.receive_complete_flag)
		|-> serial_irq)
		else $error("receive flag did not raise the interrupt");
	shift_clock_a: assert property (($fell(txd) && mode == 2'h0
		&& $stable(mode)) |-> (!txd)[*6] ##1 txd)
		else $error("mode 0 shift clock low phase is not six clocks");
	rxd_drive_mode_a: assert property (rxd_oe |-> mode == 2'h0)
		else $error("receive pin driven outside mode 0");
	frame_ten_a: assert property (($rose(s.tx_state == TX_SHIFT)
		&& mode == 2'h1) |-> s.tx_bits == 4'ha)
		else $error("mode 1 frame is not ten bits");
	frame_eleven_a: assert property (($rose(s.tx_state == TX_SHIFT)
		&& mode[1]) |-> s.tx_bits == 4'hb)
		else $error("nine-bit mode frame is not eleven bits");
	t2_flag_quiet_a: assert property ((timer2_overflow && !s.timer2_overflow_flag
		&& (s.tx_timer2_clock_select || s.rx_timer2_clock_select))
		|=> !s.timer2_overflow_flag)
		else $error("baud use of timer 2 set its overflow flag");
	rx_push_flag_a: assert property (rx_push |=> s.receive_complete_flag
		&& fifo_out_valid)
		else $error("pushed word not flagged or not readable");
	tx_start_bit_a: assert property (($rose(s.tx_state == TX_SHIFT)
		&& mode != 2'h0) |-> !txd)
		else $error("start bit not driven at frame start");
endmodule // serial_port_four_mode

/* tb/serial_partner.sv */
// Purpose: far-side serial device for the four-mode serial port
// Assumes: bit periods given in aclk cycles
// Notes:   line idles high between frames, as an async link does
`timescale 1ns/1ps
module serial_partner (
	// clock
	input  wire logic aclk,
	// line from the port
	input  wire logic txd,
	// line to the port
	output logic      line_out
);
	initial line_out = 1'b1;

	// start, then w lsb first; the trailing one doubles as stop
	task automatic send(input int nb, input int per, input logic [8:0] w);
		logic [10:0] f;
		f = {1'b1, w, 1'b0};
		for (int i = 0; i < nb; i++) begin
			line_out <= f[i];
			repeat (per) @(posedge aclk);
		end
		// one idle clock so a following call never drives in the same step
		line_out <= 1'b1;
		@(posedge aclk);
	endtask

	// mode 0 receive: bit 0 waits ready, each next bit follows a clock fall
	task automatic feed(input logic [7:0] b);
		line_out <= b[0];
		@(negedge txd);
		for (int i = 1; i < 8; i++) begin
			@(negedge txd);
			line_out <= b[i];
		end
		repeat (16) @(posedge aclk);
		line_out <= 1'b1;
	endtask

	// samples mid-bit; returns the bits after the start bit
	task automatic take(input int nb, input int per, output logic [9:0] w);
		w = 10'h0;
		@(negedge txd);
		repeat (per / 2) @(posedge aclk);
		for (int i = 0; i < nb - 1; i++) begin
			repeat (per) @(posedge aclk);
			w[i] = txd;
		end
	endtask
endmodule // serial_partner

/* tb/test_serial_port_four_mode.sv */
// Purpose: bench for the four-mode serial port
// Assumes: timer 1 pulses every 2 clocks, timer 2 every 3
// Notes:   mode 1 and mode 3 bit periods follow from those pulse rates
`timescale 1ns/1ps
module test_serial_port_four_mode;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [1:0]  r;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        rxd_in, rxd_out, rxd_oe, txd, serial_irq, line_out;
	logic        timer1_overflow = 1'b0;
	logic        timer2_overflow = 1'b0;
	logic [1:0]  c2 = 2'h0;
	logic [9:0]  w;
	int          n_errors = 0;
	int          n_checks = 0;
	time         ts;

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		timer1_overflow <= ~timer1_overflow;
		c2 <= (c2 == 2'h2) ? 2'h0 : c2 + 2'h1;
		timer2_overflow <= (c2 == 2'h2);
	end
	// the receive pin is shared with the port in mode 0
	assign rxd_in = rxd_oe ? rxd_out : line_out;

	serial_port_four_mode dut_u (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .rxd_in, .rxd_out, .rxd_oe, .txd, .timer1_overflow,
		.timer2_overflow, .serial_irq);
	serial_partner partner_u (.aclk, .txd, .line_out);

	task automatic chk(input string s, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		chk("wready", 32'h1, wready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0);
		chk("ctrl", 32'h0, v);
		rd(4'h4);
		chk("status", 32'h4, v);
		chk("txd idle", 32'h1, txd);
		rd(4'h2);
		chk("unmapped", 32'h2, r);
		wr(4'h2, 32'h0);
		chk("wr unmapped", 32'h2, r);
		wr(4'h0, 32'h46);
		chk("wr okay", 32'h0, r);
		fork
			wr(4'h8, 32'ha5);
			partner_u.take(11, 64, w);
			partner_u.send(11, 64, 9'h13c);
		join
		repeat (64) @(posedge aclk);
		chk("m2 tx", 32'h3a5, w);
		rd(4'h4);
		chk("m2 status", 32'hf, v);
		chk("irq", 32'h1, serial_irq);
		rd(4'hc);
		chk("m2 rx", 32'h13c, v);
		wr(4'h4, 32'h3);
		repeat (2) @(posedge aclk);
		chk("irq clear", 32'h0, serial_irq);
		wr(4'h0, 32'he);
		partner_u.send(11, 32, 9'h001);
		partner_u.send(11, 32, 9'h1fe);
		repeat (32) @(posedge aclk);
		rd(4'hc);
		chk("buf 1", 32'h001, v);
		rd(4'hc);
		chk("buf 2", 32'h1fe, v);
		// tx on timer 1 at 64 clocks a bit, rx on timer 2 at 48
		wr(4'h0, 32'h25);
		fork
			wr(4'h8, 32'h3c);
			partner_u.take(10, 64, w);
			partner_u.send(10, 48, 9'h15a);
		join
		repeat (64) @(posedge aclk);
		chk("m1 tx", 32'h13c, w);
		rd(4'hc);
		chk("m1 rx", 32'h15a, v);
		// tx on timer 2 at 48, rx on doubled timer 1 at 32
		wr(4'h0, 32'h5f);
		wr(4'h4, 32'h7);
		fork
			wr(4'h8, 32'hc3);
			partner_u.take(11, 48, w);
			partner_u.send(11, 32, 9'h0c3);
		join
		repeat (48) @(posedge aclk);
		chk("m3 tx", 32'h3c3, w);
		rd(4'hc);
		chk("m3 rx", 32'h0c3, v);
		rd(4'h4);
		chk("m3 status", 32'h3, v);
		wr(4'h0, 32'h0);
		fork
			wr(4'h8, 32'h96);
			for (int i = 0; i < 8; i++) begin
				@(posedge txd);
				w[i] = rxd_out;
				chk("m0 oe", 32'h1, rxd_oe);
				if (i == 0) ts = $time;
				if (i == 1) chk("m0 period", 32'd120, 32'($time - ts));
			end
		join
		chk("m0 tx", 32'h96, w[7:0]);
		// mode 0 receive starts once the receive flag is cleared
		fork
			partner_u.feed(8'h5a);
			begin
				wr(4'h0, 32'h4);
				wr(4'h4, 32'h3);
			end
		join
		rd(4'hc);
		chk("m0 rx", 32'h5a, v);
		test_done();
	end

	initial begin
		#200000;
		n_errors++;
		test_done();
	end
endmodule // test_serial_port_four_mode
